// ### ifd_pkg.sv
package ifd_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NUM_DI = 7;
	localparam int CODE_W = 8;
	localparam int VAL_W = 16;
	localparam int COUNT_DI_IDX = 5;

	// ------------------------------------------------------------
	// function codes
	// ------------------------------------------------------------
	localparam logic [7:0] FN_FORCE_AI1 = 8'h0f;
	localparam logic [7:0] FN_FORCE_AI2 = 8'h10;
	localparam logic [7:0] FN_FORCE_STOP = 8'h12;
	localparam logic [7:0] FN_UP = 8'h13;
	localparam logic [7:0] FN_DOWN = 8'h14;
	localparam logic [7:0] FN_PID_OFF = 8'h15;
	localparam logic [7:0] FN_CNT_CLR = 8'h16;
	localparam logic [7:0] FN_CNT_IN = 8'h17;
	localparam logic [7:0] FN_JOG_FWD = 8'h18;
	localparam logic [7:0] FN_JOG_REV = 8'h19;
	localparam logic [7:0] FN_TQ_SEL = 8'h1a;
	localparam logic [7:0] FN_SREG2 = 8'h1b;
	localparam logic [7:0] FN_ESTOP = 8'h1c;
	localparam logic [7:0] FN_VF1 = 8'h1d;
	localparam logic [7:0] FN_VF2 = 8'h1e;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CODES_LO = 8'h00;
	localparam logic [7:0] OFF_CODES_HI = 8'h04;
	localparam logic [7:0] OFF_CONFIG = 8'h08;
	localparam logic [7:0] OFF_ADV_CFG = 8'h0c;
	localparam logic [7:0] OFF_UPDN_RATE = 8'h10;
	localparam logic [7:0] OFF_CNT_TARGET = 8'h14;
	localparam logic [7:0] OFF_UPDN_FREQ = 8'h18;
	localparam logic [7:0] OFF_EVENT_CNT = 8'h1c;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFF_FAULT_RESET = 8'h28;
	localparam logic [7:0] OFF_ACTIVE = 8'h2c;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_RUN_EXT_BIT = 0;
	localparam int CFG_VF_BIT = 1;
	localparam int CFG_STOP_LSB = 2;
	localparam int ADV_NO_RETAIN_BIT = 7;
	localparam int RATE_DOWN_LSB = 16;
	localparam int IRQ_W = 4;
	localparam int IRQ_ESTOP = 0;
	localparam int IRQ_CNT_HIT = 1;
	localparam int IRQ_FSTOP = 2;
	localparam int IRQ_JOG = 3;
	localparam logic [31:0] RST_CODES = 32'h0000_0000;
	localparam logic [31:0] RST_CONFIG = 32'h0000_0001;
	localparam logic [15:0] RST_ADV_CFG = 16'h0000;
	localparam logic [15:0] RST_RATE = 16'h0064;
	localparam logic [15:0] RST_TARGET = 16'h0000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_PANEL,
		SRC_AI1,
		SRC_AI2
	} ifd_src_t;

	typedef enum logic [1:0] {
		JOG_IDLE,
		JOG_FWD,
		JOG_REV,
		JOG_WIND
	} ifd_jog_t;

	typedef struct packed {
		ifd_src_t freq_src;
		logic force_stop;
		logic [1:0] stop_method;
		logic pid_disable;
		logic jog_fwd;
		logic jog_rev;
		logic torque_mode;
		logic speed_reg2;
		logic output_cut;
		logic emergency_fault;
		logic vf_curve1;
		logic vf_curve2;
	} ifd_cmd_t;

endpackage : ifd_pkg

// ### ifd_dispatch.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE_01: code 16 forces reference to analog_input_2; analog_input_1 forcing wins.
// RULE_02: code 18 activation requests ramped stop using stop_method_setting.
// RULE_03: each code 19 activation adds one, each code 20 activation subtracts one.
// RULE_04: held up or down input keeps stepping at the up/down rate settings.
// RULE_05: up/down command returns to zero when stopped and display shows zero.
// RULE_06: advanced_config_word bit 7 set means up/down command is not kept.
// RULE_07: code 21 active keeps PID regulation disabled.
// RULE_08: code 22 active holds event counter at zero; counting resumes on release.
// RULE_09: count_input_6 with code 23 adds exactly one per activation, compared to target.
// RULE_10: code 24 starts forward jog only when run source is the terminals.
// RULE_11: code 25 starts reverse jog only when run source is the terminals.
// RULE_12: jog in torque mode runs in speed mode, torque mode returns afterwards.
// RULE_13: code 26 active selects torque_control_mode, else field_oriented_mode.
// RULE_14: code 27 active selects second speed_regulator gains, else first.
// RULE_15: code 28 cuts output, coasts, latches emergency_fault until cleared and reset.
// RULE_16: in V/F mode code 29 active selects the first V/F curve.
// RULE_17: in V/F mode code 30 active selects the second V/F curve; the code selects it only while code 29 is inactive.
// RULE_18: code 15 forces reference source to analog_input_1.
// RULE_19: each input has a programmable code; unassigned codes do nothing.
module ifd_dispatch (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// input terminals
	input wire logic [ifd_pkg::NUM_DI-1:0] i_di,
	// drive status
	input wire logic i_drive_stopped,
	input wire logic i_disp_freq_zero,
	// commands to the drive
	output ifd_pkg::ifd_cmd_t o_cmd,
	output logic [ifd_pkg::VAL_W-1:0] o_updn_freq,
	output logic [ifd_pkg::VAL_W-1:0] o_event_count,
	output logic o_irq
);

	// ------------------------------------------------------------
	// decode helper
	// ------------------------------------------------------------
	// any input assigned to a code and currently active
	function automatic logic fn_on(
		input logic [ifd_pkg::NUM_DI*ifd_pkg::CODE_W-1:0] codes,
		input logic [ifd_pkg::NUM_DI-1:0] lvl,
		input logic [ifd_pkg::CODE_W-1:0] code
	);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < ifd_pkg::NUM_DI; k++) begin
			if (lvl[k] && codes[k*ifd_pkg::CODE_W +: ifd_pkg::CODE_W] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : fn_on

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [ifd_pkg::NUM_DI-1:0] sync1_q;
	logic [ifd_pkg::NUM_DI-1:0] sync2_q;
	logic [ifd_pkg::NUM_DI-1:0] sync2_d;
	logic [ifd_pkg::NUM_DI*ifd_pkg::CODE_W-1:0] codes_q;
	logic [ifd_pkg::NUM_DI*ifd_pkg::CODE_W-1:0] codes_d;
	logic [31:0] config_q;
	logic [31:0] config_d;
	logic [15:0] adv_q;
	logic [15:0] adv_d;
	logic [31:0] rate_q;
	logic [31:0] rate_d;
	logic [15:0] target_q;
	logic [15:0] target_d;
	logic [ifd_pkg::IRQ_W-1:0] irq_sts_q;
	logic [ifd_pkg::IRQ_W-1:0] irq_sts_d;
	logic [ifd_pkg::IRQ_W-1:0] irq_msk_q;
	logic [ifd_pkg::IRQ_W-1:0] irq_msk_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [15:0] freq_q;
	logic [15:0] freq_d;
	logic [15:0] rate_cnt_q;
	logic [15:0] rate_cnt_d;
	logic [15:0] evt_q;
	logic [15:0] evt_d;
	logic up_q;
	logic up_d;
	logic dn_q;
	logic dn_d;
	logic cnt_in_q;
	logic cnt_in_d;
	logic fstop_q;
	logic fstop_d;
	logic estop_q;
	logic estop_d;
	logic estop_in_q;
	logic estop_in_d;
	ifd_pkg::ifd_jog_t jog_q;
	ifd_pkg::ifd_jog_t jog_d;
	ifd_pkg::ifd_cmd_t cmd_q;
	ifd_pkg::ifd_cmd_t cmd_d;

	// ------------------------------------------------------------
	// decoded functions
	// ------------------------------------------------------------
	logic f_ai1;
	logic f_ai2;
	logic f_stop;
	logic f_up;
	logic f_dn;
	logic f_pid;
	logic f_clr;
	logic f_cnt;
	logic f_jf;
	logic f_jr;
	logic f_tq;
	logic f_sr2;
	logic f_es;
	logic f_vf1;
	logic f_vf2;
	logic wr;
	logic rd_setup;
	logic mapped;
	logic run_ext;
	logic vf_mode;
	logic [15:0] up_rate;
	logic [15:0] dn_rate;

	// RULE_19 code mapping
	always_comb begin
		f_ai1 = fn_on(codes_q, sync2_q, ifd_pkg::FN_FORCE_AI1);
		f_ai2 = fn_on(codes_q, sync2_q, ifd_pkg::FN_FORCE_AI2);
		f_stop = fn_on(codes_q, sync2_q, ifd_pkg::FN_FORCE_STOP);
		f_up = fn_on(codes_q, sync2_q, ifd_pkg::FN_UP);
		f_dn = fn_on(codes_q, sync2_q, ifd_pkg::FN_DOWN);
		f_pid = fn_on(codes_q, sync2_q, ifd_pkg::FN_PID_OFF);
		f_clr = fn_on(codes_q, sync2_q, ifd_pkg::FN_CNT_CLR);
		f_jf = fn_on(codes_q, sync2_q, ifd_pkg::FN_JOG_FWD);
		f_jr = fn_on(codes_q, sync2_q, ifd_pkg::FN_JOG_REV);
		f_tq = fn_on(codes_q, sync2_q, ifd_pkg::FN_TQ_SEL);
		f_sr2 = fn_on(codes_q, sync2_q, ifd_pkg::FN_SREG2);
		f_es = fn_on(codes_q, sync2_q, ifd_pkg::FN_ESTOP);
		f_vf1 = fn_on(codes_q, sync2_q, ifd_pkg::FN_VF1);
		f_vf2 = fn_on(codes_q, sync2_q, ifd_pkg::FN_VF2);
		// only the dedicated counting terminal can count
		f_cnt = sync2_q[ifd_pkg::COUNT_DI_IDX] &&
			codes_q[ifd_pkg::COUNT_DI_IDX*ifd_pkg::CODE_W +: ifd_pkg::CODE_W] ==
			ifd_pkg::FN_CNT_IN;
	end

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	always_comb begin
		wr = i_psel && i_penable && i_pwrite;
		rd_setup = i_psel && !i_penable && !i_pwrite;
		run_ext = config_q[ifd_pkg::CFG_RUN_EXT_BIT];
		vf_mode = config_q[ifd_pkg::CFG_VF_BIT];
		up_rate = rate_q[15:0];
		dn_rate = rate_q[ifd_pkg::RATE_DOWN_LSB +: 16];
		case (i_paddr)
			ifd_pkg::OFF_CODES_LO, ifd_pkg::OFF_CODES_HI, ifd_pkg::OFF_CONFIG,
			ifd_pkg::OFF_ADV_CFG, ifd_pkg::OFF_UPDN_RATE, ifd_pkg::OFF_CNT_TARGET,
			ifd_pkg::OFF_UPDN_FREQ, ifd_pkg::OFF_EVENT_CNT, ifd_pkg::OFF_IRQ_STATUS,
			ifd_pkg::OFF_IRQ_MASK, ifd_pkg::OFF_FAULT_RESET, ifd_pkg::OFF_ACTIVE: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [ifd_pkg::IRQ_W-1:0] evts;
		logic up_edge;
		logic dn_edge;
		logic step_up;
		logic step_dn;
		logic held;
		logic [15:0] rate_sel;
		evts = '0;
		up_edge = 1'b0;
		dn_edge = 1'b0;
		step_up = 1'b0;
		step_dn = 1'b0;
		held = 1'b0;
		rate_sel = 16'h0000;
		sync2_d = sync1_q;
		codes_d = codes_q;
		config_d = config_q;
		adv_d = adv_q;
		rate_d = rate_q;
		target_d = target_q;
		irq_msk_d = irq_msk_q;
		prdata_d = prdata_q;
		up_d = f_up;
		dn_d = f_dn;
		cnt_in_d = f_cnt;
		fstop_d = f_stop;
		estop_in_d = f_es;
		freq_d = freq_q;
		rate_cnt_d = rate_cnt_q;
		evt_d = evt_q;
		estop_d = estop_q;
		jog_d = jog_q;

		// register writes
		if (wr) begin
			case (i_paddr)
				ifd_pkg::OFF_CODES_LO: begin
					codes_d[31:0] = i_pwdata;
				end
				ifd_pkg::OFF_CODES_HI: begin
					codes_d[ifd_pkg::NUM_DI*ifd_pkg::CODE_W-1:32] =
						i_pwdata[ifd_pkg::NUM_DI*ifd_pkg::CODE_W-33:0];
				end
				ifd_pkg::OFF_CONFIG: begin
					config_d = {28'h000_0000, i_pwdata[3:0]};
				end
				ifd_pkg::OFF_ADV_CFG: begin
					adv_d = i_pwdata[15:0];
				end
				ifd_pkg::OFF_UPDN_RATE: begin
					rate_d = i_pwdata;
				end
				ifd_pkg::OFF_CNT_TARGET: begin
					target_d = i_pwdata[15:0];
				end
				ifd_pkg::OFF_IRQ_MASK: begin
					irq_msk_d = i_pwdata[ifd_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// RULE_03 single steps
		up_edge = f_up && !up_q;
		dn_edge = f_dn && !dn_q;
		// RULE_04 held stepping
		held = (f_up && up_q) != (f_dn && dn_q);
		rate_sel = (f_up && up_q) ? up_rate : dn_rate;
		step_up = up_edge;
		step_dn = dn_edge;
		if (held) begin
			if (rate_cnt_q >= rate_sel) begin
				rate_cnt_d = 16'h0000;
				step_up = step_up || (f_up && up_q);
				step_dn = step_dn || (f_dn && dn_q);
			end else begin
				rate_cnt_d = rate_cnt_q + 16'h0001;
			end
		end else begin
			rate_cnt_d = 16'h0000;
		end
		if (step_up && !step_dn && freq_q != 16'hffff) begin
			freq_d = freq_q + 16'h0001;
		end else if (step_dn && !step_up && freq_q != 16'h0000) begin
			freq_d = freq_q - 16'h0001;
		end
		// RULE_05 zero at standstill
		if (i_drive_stopped && i_disp_freq_zero) begin
			freq_d = 16'h0000;
		end
		// RULE_06 no retention once stopped
		if (adv_q[ifd_pkg::ADV_NO_RETAIN_BIT] && i_drive_stopped) begin
			freq_d = 16'h0000;
		end

		// RULE_08 counter clear holds zero
		if (f_clr) begin
			evt_d = 16'h0000;
		// RULE_09 one count per activation
		end else if (f_cnt && !cnt_in_q) begin
			evt_d = evt_q + 16'h0001;
			if (evt_d == target_q) begin
				evts[ifd_pkg::IRQ_CNT_HIT] = 1'b1;
			end
		end

		// RULE_15 latch until clear and reset
		if (f_es && !estop_in_q) begin
			estop_d = 1'b1;
			evts[ifd_pkg::IRQ_ESTOP] = 1'b1;
		end else if (wr && i_paddr == ifd_pkg::OFF_FAULT_RESET && i_pwdata[0] && !f_es) begin
			estop_d = 1'b0;
		end

		// RULE_02 stop event
		if (f_stop && !fstop_q) begin
			evts[ifd_pkg::IRQ_FSTOP] = 1'b1;
		end

		// jog sequencing
		case (jog_q)
			ifd_pkg::JOG_IDLE: begin
				// RULE_10 RULE_11 terminal run source only
				if (run_ext && !estop_q && i_drive_stopped && (f_jf != f_jr)) begin
					jog_d = f_jf ? ifd_pkg::JOG_FWD : ifd_pkg::JOG_REV;
					evts[ifd_pkg::IRQ_JOG] = 1'b1;
				end
			end
			ifd_pkg::JOG_FWD: begin
				if (!f_jf || estop_q) begin
					jog_d = ifd_pkg::JOG_WIND;
				end
			end
			ifd_pkg::JOG_REV: begin
				if (!f_jr || estop_q) begin
					jog_d = ifd_pkg::JOG_WIND;
				end
			end
			ifd_pkg::JOG_WIND: begin
				// jog is complete once the decel to stop has finished
				if (i_drive_stopped) begin
					jog_d = ifd_pkg::JOG_IDLE;
				end
			end
			default: begin
				jog_d = ifd_pkg::JOG_IDLE;
			end
		endcase

		// sticky status, set beats a write-one clear
		irq_sts_d = irq_sts_q;
		if (wr && i_paddr == ifd_pkg::OFF_IRQ_STATUS) begin
			irq_sts_d = irq_sts_q & ~i_pwdata[ifd_pkg::IRQ_W-1:0];
		end
		irq_sts_d = irq_sts_d | evts;

		// read data captured in setup phase
		if (rd_setup) begin
			case (i_paddr)
				ifd_pkg::OFF_CODES_LO: prdata_d = codes_q[31:0];
				ifd_pkg::OFF_CODES_HI: prdata_d = {8'h00, codes_q[55:32]};
				ifd_pkg::OFF_CONFIG: prdata_d = config_q;
				ifd_pkg::OFF_ADV_CFG: prdata_d = {16'h0000, adv_q};
				ifd_pkg::OFF_UPDN_RATE: prdata_d = rate_q;
				ifd_pkg::OFF_CNT_TARGET: prdata_d = {16'h0000, target_q};
				ifd_pkg::OFF_UPDN_FREQ: prdata_d = {16'h0000, freq_q};
				ifd_pkg::OFF_EVENT_CNT: prdata_d = {16'h0000, evt_q};
				ifd_pkg::OFF_IRQ_STATUS: prdata_d = {28'h000_0000, irq_sts_q};
				ifd_pkg::OFF_IRQ_MASK: prdata_d = {28'h000_0000, irq_msk_q};
				ifd_pkg::OFF_FAULT_RESET: prdata_d = {31'h0000_0000, estop_q};
				ifd_pkg::OFF_ACTIVE: prdata_d = {17'h0_0000, f_vf2, f_vf1, f_es, f_sr2,
					f_tq, f_jr, f_jf, f_cnt, f_clr, f_pid, f_dn, f_up, f_stop, f_ai2, f_ai1};
				default: prdata_d = 32'h0000_0000;
			endcase
		end

		// drive commands
		// RULE_18 RULE_01 analog_input_1 has priority
		if (f_ai1) begin
			cmd_d.freq_src = ifd_pkg::SRC_AI1;
		end else if (f_ai2) begin
			cmd_d.freq_src = ifd_pkg::SRC_AI2;
		end else begin
			cmd_d.freq_src = ifd_pkg::SRC_PANEL;
		end
		// RULE_02 ramped stop request
		cmd_d.force_stop = f_stop;
		cmd_d.stop_method = config_q[ifd_pkg::CFG_STOP_LSB +: 2];
		// RULE_07 pid off
		cmd_d.pid_disable = f_pid;
		cmd_d.jog_fwd = jog_q == ifd_pkg::JOG_FWD;
		cmd_d.jog_rev = jog_q == ifd_pkg::JOG_REV;
		// RULE_13 RULE_12 speed mode during jog
		cmd_d.torque_mode = f_tq && jog_q == ifd_pkg::JOG_IDLE;
		// RULE_14 gain set
		cmd_d.speed_reg2 = f_sr2;
		// RULE_15 coast output cut
		cmd_d.output_cut = estop_d;
		cmd_d.emergency_fault = estop_d;
		// RULE_16 RULE_17 curve select
		cmd_d.vf_curve1 = vf_mode && f_vf1;
		cmd_d.vf_curve2 = vf_mode && f_vf2 && !f_vf1;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_q <= '0;
			sync2_q <= '0;
			codes_q <= '0;
			config_q <= ifd_pkg::RST_CONFIG;
			adv_q <= ifd_pkg::RST_ADV_CFG;
			rate_q <= {ifd_pkg::RST_RATE, ifd_pkg::RST_RATE};
			target_q <= ifd_pkg::RST_TARGET;
			irq_sts_q <= '0;
			irq_msk_q <= '0;
			prdata_q <= 32'h0000_0000;
			freq_q <= 16'h0000;
			rate_cnt_q <= 16'h0000;
			evt_q <= 16'h0000;
			up_q <= 1'b0;
			dn_q <= 1'b0;
			cnt_in_q <= 1'b0;
			fstop_q <= 1'b0;
			estop_q <= 1'b0;
			estop_in_q <= 1'b0;
			jog_q <= ifd_pkg::JOG_IDLE;
			cmd_q <= '0;
		end else if (i_ce) begin
			sync1_q <= i_di;
			sync2_q <= sync2_d;
			codes_q <= codes_d;
			config_q <= config_d;
			adv_q <= adv_d;
			rate_q <= rate_d;
			target_q <= target_d;
			irq_sts_q <= irq_sts_d;
			irq_msk_q <= irq_msk_d;
			prdata_q <= prdata_d;
			freq_q <= freq_d;
			rate_cnt_q <= rate_cnt_d;
			evt_q <= evt_d;
			up_q <= up_d;
			dn_q <= dn_d;
			cnt_in_q <= cnt_in_d;
			fstop_q <= fstop_d;
			estop_q <= estop_d;
			estop_in_q <= estop_in_d;
			jog_q <= jog_d;
			cmd_q <= cmd_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		o_prdata = prdata_q;
		o_pready = i_psel && i_penable && i_ce;
		o_pslverr = i_psel && i_penable && !mapped;
		o_cmd = cmd_q;
		o_updn_freq = freq_q;
		o_event_count = evt_q;
		o_irq = |(irq_sts_q & irq_msk_q);
	end

endmodule : ifd_dispatch

`default_nettype wire

// ### ifd_dispatch_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ifd_dispatch_checker (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// apb
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// drive side
	input wire logic i_drive_stopped,
	input wire logic i_disp_freq_zero,
	input wire ifd_pkg::ifd_cmd_t o_cmd,
	input wire logic [15:0] o_updn_freq,
	input wire logic [15:0] o_event_count,
	input wire logic o_irq
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	logic wr_acc;
	assign wr_acc = i_psel & i_penable & i_pwrite & o_pready;

	chk_apb_no_wait: assert property (i_psel && i_penable && i_ce |-> o_pready)
		else $error("pready missing in access phase");
	chk_unmapped_err: assert property (i_psel && i_penable && i_paddr > 8'h2c |-> o_pslverr)
		else $error("pslverr missing on unmapped address");
	chk_estop_cut: assert property (o_cmd.output_cut == o_cmd.emergency_fault)
		else $error("output cut differs from emergency fault");
	chk_estop_held: assert property ($fell(o_cmd.emergency_fault) |->
		$past(wr_acc && i_paddr == ifd_pkg::OFF_FAULT_RESET && i_pwdata[0]))
		else $error("emergency fault cleared without reset press");
	chk_src_legal: assert property (o_cmd.freq_src != 2'h3)
		else $error("illegal frequency source");
	chk_vf_single: assert property (!(o_cmd.vf_curve1 && o_cmd.vf_curve2))
		else $error("both curves selected");
	chk_jog_speed: assert property (o_cmd.jog_fwd || o_cmd.jog_rev |->
		!o_cmd.torque_mode && !(o_cmd.jog_fwd && o_cmd.jog_rev))
		else $error("jog in torque mode or both directions");
	chk_updn_zero: assert property (i_ce && i_drive_stopped && i_disp_freq_zero
		|=> o_updn_freq == 16'h0000)
		else $error("up down command not zero at standstill");
	chk_updn_unit: assert property ($changed(o_updn_freq) && !$past(i_drive_stopped)
		|-> o_updn_freq == $past(o_updn_freq) + 16'h0001
		|| o_updn_freq == $past(o_updn_freq) - 16'h0001)
		else $error("up down command moved by more than one");
	chk_count_step: assert property ($changed(o_event_count) |->
		o_event_count == 16'h0000 || o_event_count == $past(o_event_count) + 16'h0001)
		else $error("event count moved by more than one");
	chk_mask_off: assert property (wr_acc && i_paddr == ifd_pkg::OFF_IRQ_MASK
		&& i_pwdata[3:0] == 4'h0 |=> !o_irq)
		else $error("interrupt high with mask cleared");

	cov_estop: cover property ($rose(o_cmd.emergency_fault));
	cov_jog: cover property ($rose(o_cmd.jog_fwd));
	cov_irq: cover property ($rose(o_irq));
endmodule : ifd_dispatch_checker

bind ifd_dispatch ifd_dispatch_checker chk (.i_ref_clk, .i_rst_b, .i_ce, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_drive_stopped,
	.i_disp_freq_zero, .o_cmd, .o_updn_freq, .o_event_count, .o_irq);
`default_nettype wire

// ### ifd_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
module ifd_switch_model (
	// clock
	input wire logic i_ref_clk,
	// terminals, open switch reads low
	output logic [ifd_pkg::NUM_DI-1:0] o_di
);
	initial o_di = '0;

	task automatic set_di(input int idx, input logic val);
		@(posedge i_ref_clk);
		o_di[idx] <= val;
	endtask : set_di
endmodule : ifd_switch_model
`default_nettype wire

// ### ifd_dispatch_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ifd_dispatch_tb;
	logic ref_clk = 1'h0;
	logic rst_b = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic stopped = 1'h0;
	logic dzero = 1'h0;
	logic ce = 1'h1;
	logic pready, pslverr, irq, err;
	logic [31:0] prdata, rd;
	logic [6:0] di;
	logic [15:0] updn, evcnt;
	ifd_pkg::ifd_cmd_t cmd;
	logic [7:0] codes [7];
	logic [7:0] lvl [8] = '{8'h11, 8'h15, 8'h1a, 8'h1b, 8'h1d, 8'h1e, 8'h10, 8'h0f};
	int mismatches = 0;
	int checks_done = 0;

	always #5 ref_clk = ~ref_clk;

	ifd_switch_model sw (.i_ref_clk(ref_clk), .o_di(di));

	ifd_dispatch dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_di(di),
		.i_drive_stopped(stopped), .i_disp_freq_zero(dzero), .o_cmd(cmd),
		.o_updn_freq(updn), .o_event_count(evcnt), .o_irq(irq));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic print_verdict;
		if (mismatches == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			mismatches++;
			print_verdict();
		end
	endtask : apb

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check(nm, e, rd);
	endtask : rc

	task automatic put_code(input int i, input logic [7:0] c);
		codes[i] = c;
		apb(1'h1, ifd_pkg::OFF_CODES_LO, {codes[3], codes[2], codes[1], codes[0]});
		apb(1'h1, ifd_pkg::OFF_CODES_HI, {8'h00, codes[6], codes[5], codes[4]});
	endtask : put_code

	task automatic press(input int i, input logic v);
		sw.set_di(i, v);
		tick(4);
	endtask : press

	function automatic ifd_pkg::ifd_cmd_t exp_cmd(input logic [7:0] c);
		ifd_pkg::ifd_cmd_t e;
		e = '0;
		case (c)
			8'h0f: e.freq_src = ifd_pkg::SRC_AI1;
			8'h10: e.freq_src = ifd_pkg::SRC_AI2;
			8'h15: e.pid_disable = 1'h1;
			8'h1a: e.torque_mode = 1'h1;
			8'h1b: e.speed_reg2 = 1'h1;
			8'h1d: e.vf_curve1 = 1'h1;
			8'h1e: e.vf_curve2 = 1'h1;
			default: e = '0;
		endcase
		return e;
	endfunction : exp_cmd

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		foreach (codes[i]) codes[i] = 8'h00;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'h1;
		rc("config", ifd_pkg::OFF_CONFIG, 32'h1);
		rc("rate", ifd_pkg::OFF_UPDN_RATE, 32'h0064_0064);
		rc("mask", ifd_pkg::OFF_IRQ_MASK, 32'h0);
		rc("codes", ifd_pkg::OFF_CODES_LO, 32'h0);
		rc("unmapped", 8'h30, 32'h0);
		check("pslverr", 32'h1, {31'h0, err});
		// level functions and unassigned code on one terminal
		apb(1'h1, ifd_pkg::OFF_CONFIG, 32'h3);
		foreach (lvl[k]) begin
			put_code(4, lvl[k]);
			press(4, 1'h1);
			check("cmd_on", 32'(exp_cmd(lvl[k])), 32'(cmd));
			press(4, 1'h0);
			check("cmd_off", 32'h0, 32'(cmd));
		end
		// source priority
		put_code(0, 8'h10);
		put_code(1, 8'h0f);
		press(0, 1'h1);
		press(1, 1'h1);
		check("src_both", 32'(ifd_pkg::SRC_AI1), 32'(cmd.freq_src));
		press(1, 1'h0);
		check("src_ai2", 32'(ifd_pkg::SRC_AI2), 32'(cmd.freq_src));
		press(0, 1'h0);
		// forced stop with stop method 2
		apb(1'h1, ifd_pkg::OFF_CONFIG, 32'h9);
		put_code(2, 8'h12);
		press(2, 1'h1);
		check("stop_cmd", 32'h6, 32'({cmd.force_stop, cmd.stop_method}));
		rc("fstop_irq", ifd_pkg::OFF_IRQ_STATUS, 32'h4);
		press(2, 1'h0);
		apb(1'h1, ifd_pkg::OFF_IRQ_STATUS, 32'hf);
		// up and down stepping
		foreach (codes[i]) codes[i] = 8'h00;
		put_code(0, 8'h13);
		put_code(1, 8'h14);
		press(0, 1'h1);
		press(0, 1'h0);
		press(0, 1'h1);
		press(0, 1'h0);
		check("up2", 32'h2, 32'(updn));
		press(1, 1'h1);
		press(1, 1'h0);
		check("down1", 32'h1, 32'(updn));
		// short rate so that a held input steps every four cycles
		apb(1'h1, ifd_pkg::OFF_UPDN_RATE, 32'h0003_0003);
		sw.set_di(0, 1'h1);
		tick(40);
		press(0, 1'h0);
		check("held_up", 32'hc, 32'(updn));
		@(posedge ref_clk) stopped <= 1'h1;
		tick(3);
		check("retained", 32'hc, 32'(updn));
		@(posedge ref_clk) dzero <= 1'h1;
		tick(3);
		check("zero_stop", 32'h0, 32'(updn));
		@(posedge ref_clk);
		stopped <= 1'h0;
		dzero <= 1'h0;
		press(0, 1'h1);
		press(0, 1'h0);
		apb(1'h1, ifd_pkg::OFF_ADV_CFG, 32'h80);
		stopped <= 1'h1;
		tick(3);
		check("no_retain", 32'h0, 32'(updn));
		// event counter, clear and interrupt
		put_code(0, 8'h17);
		put_code(5, 8'h17);
		put_code(6, 8'h16);
		apb(1'h1, ifd_pkg::OFF_CNT_TARGET, 32'h3);
		press(0, 1'h1);
		press(0, 1'h0);
		check("cnt_di1", 32'h0, 32'(evcnt));
		repeat (3) begin
			press(5, 1'h1);
			press(5, 1'h0);
		end
		check("cnt3", 32'h3, 32'(evcnt));
		check("irq_masked", 32'h0, 32'(irq));
		rc("hit", ifd_pkg::OFF_IRQ_STATUS, 32'h2);
		apb(1'h1, ifd_pkg::OFF_IRQ_MASK, 32'h2);
		tick(2);
		check("irq_on", 32'h1, 32'(irq));
		apb(1'h1, ifd_pkg::OFF_IRQ_STATUS, 32'h2);
		tick(2);
		check("irq_clr", 32'h0, 32'(irq));
		press(6, 1'h1);
		press(5, 1'h1);
		press(5, 1'h0);
		check("cnt_clr", 32'h0, 32'(evcnt));
		press(6, 1'h0);
		press(5, 1'h1);
		press(5, 1'h0);
		check("cnt_resume", 32'h1, 32'(evcnt));
		// clock enable low freezes the counting path
		@(posedge ref_clk) ce <= 1'h0;
		press(5, 1'h1);
		press(5, 1'h0);
		check("ce_freeze", 32'h1, 32'(evcnt));
		@(posedge ref_clk) ce <= 1'h1;
		// jog and torque mode
		foreach (codes[i]) codes[i] = 8'h00;
		put_code(0, 8'h18);
		put_code(1, 8'h19);
		put_code(2, 8'h1a);
		apb(1'h1, ifd_pkg::OFF_CONFIG, 32'h1);
		press(2, 1'h1);
		check("torque", 32'h1, 32'(cmd.torque_mode));
		press(0, 1'h1);
		check("jog_fwd", 32'h2, 32'({cmd.jog_fwd, cmd.torque_mode}));
		press(0, 1'h0);
		tick(2);
		check("jog_end", 32'h1, 32'({cmd.jog_fwd, cmd.torque_mode}));
		press(2, 1'h0);
		press(1, 1'h1);
		check("jog_rev", 32'h1, 32'(cmd.jog_rev));
		press(1, 1'h0);
		tick(2);
		apb(1'h1, ifd_pkg::OFF_CONFIG, 32'h0);
		press(1, 1'h1);
		check("jog_blocked", 32'h0, 32'(cmd.jog_rev));
		press(1, 1'h0);
		// emergency stop latch
		put_code(3, 8'h1c);
		apb(1'h1, ifd_pkg::OFF_IRQ_MASK, 32'h1);
		press(3, 1'h1);
		check("estop", 32'h3, 32'({cmd.output_cut, cmd.emergency_fault}));
		check("estop_irq", 32'h1, 32'(irq));
		apb(1'h1, ifd_pkg::OFF_FAULT_RESET, 32'h1);
		press(3, 1'h0);
		check("estop_held", 32'h1, 32'(cmd.emergency_fault));
		apb(1'h1, ifd_pkg::OFF_FAULT_RESET, 32'h1);
		tick(2);
		check("estop_clr", 32'h0, 32'(cmd.emergency_fault));
		rc("fault_rd", ifd_pkg::OFF_FAULT_RESET, 32'h0);
		// emergency status stays set, clearing the mask must drop the line
		apb(1'h1, ifd_pkg::OFF_IRQ_MASK, 32'h0);
		tick(2);
		check("irq_mask0", 32'h0, 32'(irq));
		print_verdict();
	end
endmodule : ifd_dispatch_tb
`default_nettype wire
